// ==== hw/uib_bank_mem.v ====
// Two bank packet store with a byte write port and a byte read port.
// The caller may read and write one bank in one cycle; a read of the written address gets the old byte.
`timescale 1ns/100ps
`include "uib_consts.vh"
module uib_bank_mem (
  // Clock.
  input wire core_clk,
  // Write port.
  input wire wr_en,
  input wire wr_bank,
  input wire [5:0] wr_addr,
  input wire [7:0] wr_data,
  // Read port.
  input wire rd_bank,
  input wire [5:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:`UIB_BANKS*`UIB_BANK_BYTES-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[{wr_bank, wr_addr}] <= wr_data;
    end
    rd_data <= mem[{rd_bank, rd_addr}];
  end
endmodule

// ==== hw/uib_consts.vh ====
// Constants for the USB IN endpoint bank manager.
// Included by the bank manager and its APB register slave.
`ifndef UIB_CONSTS_VH
`define UIB_CONSTS_VH
// Register byte offsets.
`define UIB_OFF_STATUS 12'h000
`define UIB_OFF_MASK 12'h004
`define UIB_OFF_MASK_SET 12'h008
`define UIB_OFF_DISABLE 12'h00c
`define UIB_OFF_FIFO 12'h010
`define UIB_OFF_CFG 12'h014
`define UIB_OFF_IRQ_STAT 12'h018
`define UIB_OFF_IRQ_MASK 12'h01c
// Status register field positions.
`define UIB_BIT_FREE 0
`define UIB_BIT_OWNED 1
`define UIB_BIT_WRITABLE 2
`define UIB_BIT_CFGD 3
`define UIB_POS_CUR 4
`define UIB_POS_BYTES 8
// Disable/clear register bits.
`define UIB_BIT_FREE_CLR 0
`define UIB_BIT_HANDOVER_CLR 1
`define UIB_BIT_IRQ_EN 0
// Config register fields.
`define UIB_BIT_CFG_EN 0
`define UIB_BIT_CFG_TWO 1
// Event status bits.
`define UIB_EV_FREE 0
`define UIB_EV_SENT 1
`define UIB_EV_NAK 2
// Sizes and reset values.
`define UIB_BANK_BYTES 64
`define UIB_BANKS 2
`define UIB_RST_ZERO 32'h0000_0000
`endif

// ==== hw/uib_in_endpoint.v ====
// USB device IN endpoint bank manager with an APB register slave.
// Assumes a packet engine on core_clk that raises in_req_pulse per IN token.
// Function
// - Packets leave only in answer to an IN request from the host.
// - A free current bank sets the free flag and ownership bit together.
// - The endpoint interrupt is high while free flag and its enable are set.
// - Writing the free-flag clear bit clears the flag and leaves the FIFO.
// - The handover clear bit drops ownership and readies the bank to send.
// - With two banks the handover moves on and flags show the next bank.
// - The writable flag is held while the current bank is software owned and not full.
`timescale 1ns/100ps
`include "uib_consts.vh"
module uib_in_endpoint (
  // Clock and reset.
  input wire core_clk,
  input wire arst_n,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Packet engine side.
  input wire in_req_pulse,
  input wire tx_byte_ready,
  output wire tx_nak_pulse,
  output reg tx_valid,
  output reg [7:0] tx_data,
  output reg tx_last,
  // Interrupts.
  output wire endpoint_interrupt,
  output wire irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_SEND = 3'b100;

  reg [2:0] state_r;
  reg cfg_en_r;
  reg cfg_two_r;
  reg in_bank_free_flag_r;
  reg in_free_irq_enable_r;
  reg cur_bank_r;
  reg tx_bank_r;
  reg [1:0] ready_r;
  reg [6:0] count_r [0:1];
  reg [5:0] rd_ptr_r;
  reg [6:0] tx_len_r;
  reg [2:0] ev_stat_r;
  reg [2:0] ev_mask_r;
  reg sent_done;
  reg [2:0] ev_set;
  wire [7:0] mem_rd;
  wire wr_cyc;
  wire rd_cyc;
  wire bank_software_owned;
  wire bank_writable_flag;
  wire fifo_wr;
  wire free_clr;
  wire handover_clr;
  wire nak;
  wire start_send;
  wire [6:0] cur_count;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_cyc = psel & penable & pwrite;
  assign rd_cyc = psel & penable & ~pwrite;
  assign cur_count = count_r[cur_bank_r];
  // The current bank is software owned while not yet handed to the engine.
  assign bank_software_owned = cfg_en_r & ~ready_r[cur_bank_r];
  assign bank_writable_flag = bank_software_owned &
    (cur_count < `UIB_BANK_BYTES);
  assign fifo_wr = wr_cyc & (paddr == `UIB_OFF_FIFO) &
    bank_writable_flag;
  assign free_clr = wr_cyc & (paddr == `UIB_OFF_DISABLE) &
    pwdata[`UIB_BIT_FREE_CLR];
  // Handover is only honoured after the free flag is acknowledged.
  assign handover_clr = wr_cyc & (paddr == `UIB_OFF_DISABLE) &
    pwdata[`UIB_BIT_HANDOVER_CLR] & bank_software_owned &
    ~(in_bank_free_flag_r & ~free_clr);
  assign start_send = (state_r == ST_IDLE) & in_req_pulse &
    cfg_en_r & ready_r[tx_bank_r];
  assign nak = (state_r == ST_IDLE) & in_req_pulse &
    ~(cfg_en_r & ready_r[tx_bank_r]);
  assign tx_nak_pulse = nak;
  assign endpoint_interrupt = in_bank_free_flag_r &
    in_free_irq_enable_r;
  assign irq = |(ev_stat_r & ev_mask_r);

  uib_bank_mem u_mem (
    .core_clk(core_clk),
    .wr_en(fifo_wr),
    .wr_bank(cur_bank_r),
    .wr_addr(cur_count[5:0]),
    .wr_data(pwdata[7:0]),
    .rd_bank(tx_bank_r),
    .rd_addr(rd_ptr_r),
    .rd_data(mem_rd)
  );

  always @* begin
    sent_done = (state_r == ST_SEND) & tx_valid & tx_ready_ok(tx_last);
    ev_set = 3'b000;
    ev_set[`UIB_EV_SENT] = sent_done;
    ev_set[`UIB_EV_NAK] = nak;
  end

  function tx_ready_ok;
    input last;
    begin
      tx_ready_ok = tx_byte_ready & last;
    end
  endfunction

  // Software side of the bank state: free flag, fill counts, current bank.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_en_r <= 1'b0;
      cfg_two_r <= 1'b0;
      in_bank_free_flag_r <= 1'b0;
      in_free_irq_enable_r <= 1'b0;
      cur_bank_r <= 1'b0;
      count_r[0] <= 7'h00;
      count_r[1] <= 7'h00;
      ready_r <= 2'b00;
      ev_stat_r <= 3'h0;
      ev_mask_r <= 3'h0;
    end else begin
      if (wr_cyc & (paddr == `UIB_OFF_CFG)) begin
        cfg_en_r <= pwdata[`UIB_BIT_CFG_EN];
        cfg_two_r <= pwdata[`UIB_BIT_CFG_TWO];
        in_bank_free_flag_r <= pwdata[`UIB_BIT_CFG_EN];
        cur_bank_r <= 1'b0;
        ready_r <= 2'b00;
        count_r[0] <= 7'h00;
        count_r[1] <= 7'h00;
      end else begin
        if (fifo_wr) begin
          count_r[cur_bank_r] <= cur_count + 7'h01;
        end
        if (handover_clr) begin
          ready_r[cur_bank_r] <= 1'b1;
          if (cfg_two_r) begin
            cur_bank_r <= ~cur_bank_r;
            // The next bank's own state decides the free flag.
            // A bank that finishes sending now is free as well.
            in_bank_free_flag_r <= ~ready_r[~cur_bank_r] |
              (sent_done & (tx_bank_r == ~cur_bank_r));
          end else begin
            in_bank_free_flag_r <= 1'b0;
          end
        end else if (sent_done & (tx_bank_r == cur_bank_r)) begin
          // The bank just sent is free again; flag and owner rise together.
          in_bank_free_flag_r <= 1'b1;
        end else if (free_clr) begin
          in_bank_free_flag_r <= 1'b0;
        end
        if (sent_done) begin
          ready_r[tx_bank_r] <= 1'b0;
          count_r[tx_bank_r] <= 7'h00;
        end
      end
      if (wr_cyc & (paddr == `UIB_OFF_MASK_SET)) begin
        in_free_irq_enable_r <= in_free_irq_enable_r |
          pwdata[`UIB_BIT_IRQ_EN];
      end else if (wr_cyc & (paddr == `UIB_OFF_DISABLE) &
                   pwdata[`UIB_BIT_IRQ_EN + 2]) begin
        in_free_irq_enable_r <= 1'b0;
      end
      if (wr_cyc & (paddr == `UIB_OFF_IRQ_MASK)) begin
        ev_mask_r <= pwdata[2:0];
      end
      // A read clears the events, but an event in the same cycle stays.
      if (rd_cyc & (paddr == `UIB_OFF_IRQ_STAT)) begin
        ev_stat_r <= ev_set;
      end else begin
        ev_stat_r <= ev_stat_r | ev_set;
      end
      ev_stat_r[`UIB_EV_FREE] <= (rd_cyc & (paddr == `UIB_OFF_IRQ_STAT) ?
        1'b0 : ev_stat_r[`UIB_EV_FREE]) |
        (sent_done & (tx_bank_r == cur_bank_r));
    end
  end

  // Transmit engine: streams one handed-over bank per accepted IN request.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      tx_bank_r <= 1'b0;
      rd_ptr_r <= 6'h00;
      tx_len_r <= 7'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          tx_valid <= 1'b0;
          tx_last <= 1'b0;
          rd_ptr_r <= 6'h00;
          if (wr_cyc & (paddr == `UIB_OFF_CFG)) begin
            tx_bank_r <= 1'b0;
          end else if (start_send) begin
            tx_len_r <= count_r[tx_bank_r];
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Memory read latency is one cycle; zero length sends one empty
          // beat with tx_last set and no data meaning.
          tx_data <= mem_rd;
          tx_valid <= 1'b1;
          tx_last <= (tx_len_r <= 7'h01);
          rd_ptr_r <= rd_ptr_r + 6'h01;
          state_r <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_byte_ready) begin
            if (tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              if (cfg_two_r) begin
                tx_bank_r <= ~tx_bank_r;
              end
              state_r <= ST_IDLE;
            end else begin
              tx_valid <= 1'b0;
              state_r <= ST_LOAD;
              tx_len_r <= tx_len_r - 7'h01;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data mux.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= `UIB_RST_ZERO;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= `UIB_RST_ZERO;
      case (paddr)
        `UIB_OFF_STATUS: begin
          prdata[`UIB_BIT_FREE] <= in_bank_free_flag_r;
          prdata[`UIB_BIT_OWNED] <= bank_software_owned;
          prdata[`UIB_BIT_WRITABLE] <= bank_writable_flag;
          prdata[`UIB_BIT_CFGD] <= cfg_en_r;
          prdata[`UIB_POS_CUR] <= cur_bank_r;
          prdata[`UIB_POS_BYTES +: 7] <= cur_count;
        end
        `UIB_OFF_MASK: begin
          prdata[`UIB_BIT_IRQ_EN] <= in_free_irq_enable_r;
        end
        `UIB_OFF_CFG: begin
          prdata[1:0] <= {cfg_two_r, cfg_en_r};
        end
        `UIB_OFF_IRQ_STAT: begin
          prdata[2:0] <= ev_stat_r;
        end
        `UIB_OFF_IRQ_MASK: begin
          prdata[2:0] <= ev_mask_r;
        end
        default: begin
          prdata <= `UIB_RST_ZERO;
        end
      endcase
    end
  end
endmodule

// ==== tb/uib_in_endpoint_checker.sv ====
// Port assertions for the IN endpoint bank manager.
// Bound onto the design by the bench top file.
`timescale 1ns/100ps
`include "uib_consts.vh"
module uib_in_endpoint_checker (
  // Clock, reset and APB.
  input wire core_clk, arst_n, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire pready, pslverr,
  // Packet side and interrupts.
  input wire in_req_pulse, tx_byte_ready, tx_nak_pulse, tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last, endpoint_interrupt, irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire dis_wr = psel && penable && pwrite && paddr == `UIB_OFF_DISABLE;
  wire rd_setup = psel && !penable && !pwrite;
  wire taken = tx_valid && tx_byte_ready;
  property p_nak; tx_nak_pulse |-> in_req_pulse && !tx_valid; endproperty
  a_nak: assert property (p_nak) else $error("stray nak");
  property p_src;
    $rose(tx_valid) |-> $past(in_req_pulse, 2) || $past(taken, 2);
  endproperty
  a_src: assert property (p_src) else $error("unasked data");
  property p_hold;
    tx_valid && !tx_byte_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_last; tx_last |-> tx_valid; endproperty
  a_last: assert property (p_last) else $error("bare last");
  property p_apb; psel |-> pready && !pslverr; endproperty
  a_apb: assert property (p_apb) else $error("apb answer");
  property p_rdata; !rd_setup |=> $stable(prdata); endproperty
  a_rdata: assert property (p_rdata) else $error("prdata moved");
  property p_ack; dis_wr && pwdata[0] |=> !endpoint_interrupt; endproperty
  a_ack: assert property (p_ack) else $error("ack kept irq");
  property p_off; dis_wr && pwdata[2] |=> !endpoint_interrupt; endproperty
  a_off: assert property (p_off) else $error("disable kept irq");
  c_pkt: cover property (taken && tx_last);
  c_nak: cover property (tx_nak_pulse);
  c_irq: cover property (irq && endpoint_interrupt);
endmodule

// ==== tb/uib_usb_host.sv ====
// Host model: issues IN tokens and sinks the byte stream with stalls.
// Assumes the bench asks for each token by a one-cycle in_go pulse.
`timescale 1ns/100ps
module uib_usb_host (
  // Clock and reset.
  input wire core_clk, arst_n,
  // Bench request and device stream.
  input wire in_go, tx_valid, tx_last,
  input wire [7:0] tx_data,
  // Token, flow control and received bytes.
  output reg in_req_pulse, tx_byte_ready, rx_stb,
  output reg [8:0] rx_word
);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_req_pulse <= 1'b0;
      tx_byte_ready <= 1'b0;
      rx_stb <= 1'b0;
      rx_word <= 9'h000;
    end else begin
      in_req_pulse <= in_go;
      tx_byte_ready <= ($urandom % 3) != 0;
      rx_stb <= tx_valid && tx_byte_ready;
      rx_word <= {tx_last, tx_data};
    end
  end
endmodule

// ==== tb/usb_device_in_endpoint_banks_bench.sv ====
// Self-checking bench for the IN endpoint bank manager.
// Assumes hw/ on the include path and the host model beside it.
`timescale 1ns/100ps
`include "uib_consts.vh"
module usb_device_in_endpoint_banks_bench;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg in_go = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  wire pready, pslverr, in_req_pulse, tx_byte_ready, tx_nak_pulse;
  wire tx_valid, tx_last, endpoint_interrupt, irq, rx_stb;
  wire [31:0] prdata;
  wire [7:0] tx_data;
  wire [8:0] rx_word;
  integer num_errors = 0;
  integer checks_done = 0;
  logic [63:0] exq[$];
  logic [63:0] e;
  logic [7:0] pk[$];
  always #2 core_clk = ~core_clk;
  uib_in_endpoint i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .in_req_pulse(in_req_pulse), .tx_byte_ready(tx_byte_ready),
    .tx_nak_pulse(tx_nak_pulse), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .endpoint_interrupt(endpoint_interrupt), .irq(irq));
  uib_usb_host i_host (.core_clk(core_clk), .arst_n(arst_n),
    .in_go(in_go), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_data(tx_data), .in_req_pulse(in_req_pulse),
    .tx_byte_ready(tx_byte_ready), .rx_stb(rx_stb), .rx_word(rx_word));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (exq.size() != 0) num_errors = num_errors + 1;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
    exq.push_back({m, x});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic lv(input logic ep, input logic iq);
    @(negedge core_clk);
    check(endpoint_interrupt, ep);
    check(irq, iq);
  endtask
  task automatic go_drain;
    integer n;
    n = 0;
    @(posedge core_clk);
    in_go <= 1'b1;
    @(posedge core_clk);
    in_go <= 1'b0;
    while (exq.size() != 0 && n < 3000) begin
      @(posedge core_clk);
      n = n + 1;
    end
  endtask
  task automatic fill(input integer n);
    logic [31:0] d;
    repeat (n) begin
      d = $urandom;
      apb(1'b1, `UIB_OFF_FIFO, d);
      if (pk.size() < `UIB_BANK_BYTES) pk.push_back(d[7:0]);
    end
  endtask
  task automatic send;
    integer i, k;
    k = pk.size();
    for (i = 0; i < k; i = i + 1)
      exq.push_back({32'h1ff, 23'h0, i == k - 1, pk.pop_front()});
    go_drain();
  endtask
  always @(posedge core_clk) begin
    if ((psel && penable && pready && !pwrite) || rx_stb || tx_nak_pulse)
    begin
      e = exq.size() ? exq.pop_front() : {32'hffff_ffff, 32'hffff_ffff};
      if (rx_stb)
        check({23'h0, rx_word} & e[63:32], e[31:0]);
      else if (tx_nak_pulse)
        check({22'h0, tx_nak_pulse, tx_valid, tx_last, 7'h0} & e[63:32],
          e[31:0]);
      else
        check(prdata & e[63:32], e[31:0]);
    end
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    tally_and_finish();
  end
  initial begin
    void'($urandom(49997));
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`UIB_OFF_STATUS, 32'hffff_ffff, 32'h0);
    rd(12'h020, 32'hffff_ffff, 32'h0);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    rd(`UIB_OFF_MASK, 32'hffff_ffff, 32'h0);
    lv(1'b0, 1'b0);
    apb(1'b1, `UIB_OFF_CFG, 32'h1);
    apb(1'b1, `UIB_OFF_MASK_SET, 32'h1);
    apb(1'b1, `UIB_OFF_IRQ_MASK, 32'h2);
    rd(`UIB_OFF_STATUS, 32'h7fff, 32'h000f);
    lv(1'b1, 1'b0);
    exq.push_back({32'hffff_ffff, 32'h200});
    go_drain();
    apb(1'b1, `UIB_OFF_DISABLE, 32'h2);
    rd(`UIB_OFF_STATUS, 32'h7fff, 32'h000f);
    apb(1'b1, `UIB_OFF_DISABLE, 32'h4);
    lv(1'b0, 1'b0);
    apb(1'b1, `UIB_OFF_MASK_SET, 32'h1);
    apb(1'b1, `UIB_OFF_DISABLE, 32'h1);
    lv(1'b0, 1'b0);
    fill(3);
    apb(1'b1, `UIB_OFF_DISABLE, 32'h1);
    fill(2);
    rd(`UIB_OFF_STATUS, 32'h7f0f, 32'h050e);
    apb(1'b1, `UIB_OFF_DISABLE, 32'h2);
    send();
    rd(`UIB_OFF_STATUS, 32'h000f, 32'h000f);
    lv(1'b1, 1'b1);
    apb(1'b1, `UIB_OFF_IRQ_MASK, 32'h0);
    lv(1'b1, 1'b0);
    apb(1'b1, `UIB_OFF_IRQ_MASK, 32'h2);
    lv(1'b1, 1'b1);
    rd(`UIB_OFF_IRQ_STAT, 32'h2, 32'h2);
    lv(1'b1, 1'b0);
    apb(1'b1, `UIB_OFF_CFG, 32'h3);
    apb(1'b1, `UIB_OFF_DISABLE, 32'h1);
    fill(65);
    rd(`UIB_OFF_STATUS, 32'h4, 32'h0);
    apb(1'b1, `UIB_OFF_DISABLE, 32'h2);
    rd(`UIB_OFF_STATUS, 32'h7fff, 32'h001f);
    lv(1'b1, 1'b0);
    send();
    tally_and_finish();
  end
endmodule
bind uib_in_endpoint uib_in_endpoint_checker i_chk (.*);
